// File: core/nibble_bidir_io_port.v
// 8-bit nibble-direction i/o port with ahb-lite register access
// assumes one ahb-lite master, board pads resolve pin level from enables
//
// Behaviour
// - a port read returns the synchronised pin level, never the output latch.
// - the input sampling path stays active for every bit in any direction.
// - an or/and/xor operation reads the pins, combines with the operand and writes the latch.
// - the pull-up of a nibble is switched off while that nibble is an output.
// - direction is chosen per nibble through the mode register, never per bit.
// - one configuration bit selects push-pull or open-drain drivers.
// - after hardware reset both nibbles are inputs.
// - stop-mode recovery forces both nibbles back to input.
// - pull-up presence per nibble is a build-time parameter.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "nibble_port_defs.vh"
module nibble_bidir_io_port
#(
    parameter PULLUP_LO = `PULLUP_LO_DEFAULT,
    parameter PULLUP_HI = `PULLUP_HI_DEFAULT
)
(
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // stop-mode recovery pulse
    input wire stop_wake_recovery,
    // port pins
    input wire [7:0] first_port_pins_in,
    output reg [7:0] first_port_pins_out,
    output reg [7:0] first_port_pins_oe,
    output reg [7:0] first_port_pullup_en
);

// ----------------------------------------
// state
// ----------------------------------------
reg [7:0] first_port_data;
reg [1:0] port_mode;
reg port_driver_config_reg;
reg wr_pend;
reg [7:0] wr_addr;
reg [7:0] next_latch;
reg [7:0] next_out;
reg [7:0] next_oe;
reg [7:0] next_pull;
reg [31:0] next_rdata;
wire [7:0] pin_level;
wire addr_ok;
wire [1:0] rmw_op;

wire [7:0] build_pullup;

function [7:0] nibble_mask;
    input [1:0] mode;
    begin
        nibble_mask = {{4{mode[1]}}, {4{mode[0]}}};
    end
endfunction

// write data phase aimed at one register
function wr_hit;
    input pend;
    input [7:0] addr;
    input [7:0] ofs;
    begin
        wr_hit = pend && (addr == ofs);
    end
endfunction

// ----------------------------------------
// build-time pull-up options
// ----------------------------------------
genvar g;
generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_pull
        if (g < 4)
        begin : g_lo
            assign build_pullup[g] = (PULLUP_LO != 0);
        end
        else
        begin : g_hi
            assign build_pullup[g] = (PULLUP_HI != 0);
        end
    end
endgenerate

// ----------------------------------------
// pin input path
// ----------------------------------------
pin_sync u_sync
(
    .mclk(mclk),
    .arst_n(arst_n),
    .async_in(first_port_pins_in),
    .sync_out(pin_level)
);

// ----------------------------------------
// bus slave
// ----------------------------------------
assign addr_ok = hsel && hready && htrans[1];
assign rmw_op = hwdata[`RMW_OP_LSB+1:`RMW_OP_LSB];

always @*
begin
    case (haddr)
        `OFS_PORT_DATA: next_rdata = {24'h000000, pin_level};
        `OFS_PORT_MODE: next_rdata = {30'h00000000, port_mode};
        `OFS_PORT_CONFIG: next_rdata = {29'h00000000, port_driver_config_reg, 2'h0};
        `OFS_PORT_LATCH: next_rdata = {24'h000000, first_port_data};
        default: next_rdata = 32'h00000000;
    endcase
end

always @*
begin
    next_latch = first_port_data;
    if (wr_hit(wr_pend, wr_addr, `OFS_PORT_DATA))
    begin
        next_latch = hwdata[7:0];
    end
    else if (wr_hit(wr_pend, wr_addr, `OFS_PORT_RMW))
    begin
        case (rmw_op)
            `RMW_OP_OR: next_latch = pin_level | hwdata[7:0];
            `RMW_OP_AND: next_latch = pin_level & hwdata[7:0];
            `RMW_OP_XOR: next_latch = pin_level ^ hwdata[7:0];
            default: next_latch = first_port_data;
        endcase
    end
end

always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        wr_pend <= 1'b0;
        wr_addr <= 8'h00;
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        first_port_data <= `RST_LATCH;
        port_mode <= `RST_MODE;
        port_driver_config_reg <= `RST_CONFIG;
    end
    else
    begin
        wr_pend <= addr_ok && hwrite;
        if (addr_ok)
        begin
            wr_addr <= haddr;
        end
        if (addr_ok && !hwrite)
        begin
            hrdata <= next_rdata;
        end
        first_port_data <= next_latch;
        if (wr_hit(wr_pend, wr_addr, `OFS_PORT_CONFIG))
        begin
            port_driver_config_reg <= hwdata[`OPEN_DRAIN_BIT];
        end
        if (stop_wake_recovery)
        begin
            port_mode <= `RST_MODE;
        end
        else if (wr_hit(wr_pend, wr_addr, `OFS_PORT_MODE))
        begin
            port_mode <= {hwdata[`MODE_HI_OUT_BIT], hwdata[`MODE_LO_OUT_BIT]};
        end
    end
end

// ----------------------------------------
// pin drivers
// ----------------------------------------
always @*
begin
    next_out = port_driver_config_reg ? 8'h00 : first_port_data;
    next_oe = nibble_mask(port_mode);
    if (port_driver_config_reg)
    begin
        next_oe = nibble_mask(port_mode) & ~first_port_data;
    end
    next_pull = ~nibble_mask(port_mode) & build_pullup;
end

always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        first_port_pins_out <= 8'h00;
        first_port_pins_oe <= 8'h00;
        first_port_pullup_en <= 8'h00;
    end
    else
    begin
        first_port_pins_out <= next_out;
        first_port_pins_oe <= next_oe;
        first_port_pullup_en <= next_pull;
    end
end

endmodule

// File: core/nibble_port_defs.vh
// register offsets, field positions, reset values for the nibble port
// assumes a 32-bit ahb-lite slave with word-aligned registers
`ifndef NIBBLE_PORT_DEFS_VH
`define NIBBLE_PORT_DEFS_VH

`define OFS_PORT_DATA 8'h00
`define OFS_PORT_MODE 8'h04
`define OFS_PORT_CONFIG 8'h08
`define OFS_PORT_RMW 8'h0C
`define OFS_PORT_LATCH 8'h10
`define MODE_LO_OUT_BIT 0
`define MODE_HI_OUT_BIT 1
`define OPEN_DRAIN_BIT 2
`define RMW_OP_LSB 8
`define RMW_OP_OR 2'h1
`define RMW_OP_AND 2'h2
`define RMW_OP_XOR 2'h3
`define RST_LATCH 8'h00
`define RST_MODE 2'h0
`define RST_CONFIG 1'b0
`define PULLUP_LO_DEFAULT 1'b1
`define PULLUP_HI_DEFAULT 1'b1

`endif

// File: core/pin_sync.v
// two-flop synchroniser for the eight port pins
// assumes pins are asynchronous to mclk
`timescale 1ns/1ns
module pin_sync
(
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // data
    input wire [7:0] async_in,
    output reg [7:0] sync_out
);

reg [7:0] meta;

always @(posedge mclk or negedge arst_n)
begin
    if (!arst_n)
    begin
        meta <= 8'h00;
        sync_out <= 8'h00;
    end
    else
    begin
        meta <= async_in;
        sync_out <= meta;
    end
end

endmodule

// File: sim/nibble_port_monitor.sv
// bus answer and pin control assertions
// assumes binding to the port's own ports
`timescale 1ns/1ns
`include "nibble_port_defs.vh"
module nibble_port_monitor
#(
    parameter PULLUP_LO = 1,
    parameter PULLUP_HI = 1
)
(
    // clock and reset
    input wire mclk,
    input wire arst_n,
    // bus
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    // port
    input wire stop_wake_recovery,
    input wire [7:0] first_port_pins_in,
    input wire [7:0] first_port_pins_oe,
    input wire [7:0] first_port_pullup_en
);
    wire rd = hsel && hready && htrans[1] && !hwrite;
    wire rdp = rd && haddr == `OFS_PORT_DATA;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    bus_ok_a: assert property (hreadyout && !hresp) else $error("bus not okay");
    rd_pin_a: assert property ($stable(first_port_pins_in)[*3] ##0 ($past(arst_n, 2) && rdp)
        |=> hrdata[7:0] == $past(first_port_pins_in)) else $error("pin read");
    unm_rd_a: assert property (rd && haddr == 8'h20 |=> hrdata == 32'h0) else $error("unmapped read");
    pu_lo_a: assert property ((|first_port_pins_oe[3:0]) |-> first_port_pullup_en[3:0] == 4'h0)
        else $error("low pull-up on");
    pu_hi_a: assert property ((|first_port_pins_oe[7:4]) |-> first_port_pullup_en[7:4] == 4'h0)
        else $error("high pull-up on");
    rst_in_a: assert property ($rose(arst_n) |-> first_port_pins_oe == 8'h00) else $error("reset oe");
    rst_pu_a: assert property ($rose(arst_n) |=> first_port_pullup_en == {{4{PULLUP_HI != 0}}, {4{PULLUP_LO != 0}}})
        else $error("reset pull-up");
    swr_in_a: assert property (stop_wake_recovery |-> ##2 first_port_pins_oe == 8'h00) else $error("stop oe");
endmodule
bind nibble_bidir_io_port nibble_port_monitor #(.PULLUP_LO(PULLUP_LO), .PULLUP_HI(PULLUP_HI)) mon (.*);

// File: sim/board_model.sv
// board circuitry on the port pins
// assumes the core drives from mclk edges
`timescale 1ns/1ns
module board_model
(
    // clock
    input wire mclk,
    // core side
    input wire [7:0] drv,
    input wire [7:0] drv_en,
    input wire [7:0] pull_en,
    // external sources
    input wire [7:0] ext,
    input wire [7:0] ext_en,
    // resolved level
    output wire [7:0] pin
);
    reg [7:0] flt = 8'h55;
    always @(posedge mclk)
        flt <= ~flt;
    // undriven bits without pull-up float
    assign pin = (drv_en & drv) | (~drv_en & ext_en & ext) | (~drv_en & ~ext_en & (pull_en | flt));
endmodule

// File: sim/nibble_bidir_io_port_tb.sv
// bench: reset, random port traffic, stop recovery
// assumes the board model resolves pin levels
`timescale 1ns/1ns
`include "nibble_port_defs.vh"
module nibble_bidir_io_port_tb;
    reg mclk = 0, arst_n = 0, hwrite = 0, swr = 0, od;
    reg [1:0] htrans = 0, m, op;
    reg [7:0] haddr = 0, ext = 0, ext_en = 0, l, d, eo, ev, kn, ex;
    reg [31:0] hwdata = 0, r;
    wire [31:0] hrdata;
    wire hreadyout;
    wire [7:0] pin, po, oe, pu;
    integer n_fail = 0, check_count = 0, i;
    always #20 mclk = ~mclk;
    nibble_bidir_io_port dut (.mclk(mclk), .arst_n(arst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(), .stop_wake_recovery(swr), .first_port_pins_in(pin),
        .first_port_pins_out(po), .first_port_pins_oe(oe), .first_port_pullup_en(pu));
    board_model brd (.mclk(mclk), .drv(po), .drv_en(oe), .pull_en(pu), .ext(ext), .ext_en(ext_en), .pin(pin));
    function [7:0] nib_mask(input [1:0] mm);
        nib_mask = {{4{mm[1]}}, {4{mm[0]}}};
    endfunction
    task chk(input [31:0] seen, input [31:0] exp, input string what);
        begin
            check_count = check_count + 1;
            if (seen !== exp)
            begin
                n_fail = n_fail + 1;
                $display("unexpected %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task xfer(input w, input [7:0] a, input [31:0] wd);
        begin
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            do @(posedge mclk); while (hreadyout !== 1'b1);
            htrans <= 2'h0;
            hwdata <= wd;
            do @(posedge mclk); while (hreadyout !== 1'b1);
            r = hrdata;
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d fails %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    initial
    begin
        #100000;
        n_fail = n_fail + 1;
        wrap_up;
    end
    initial
    begin
        void'($urandom(79));
        repeat (2) @(posedge mclk);
        arst_n <= 1;
        xfer(0, `OFS_PORT_MODE, 0);
        chk(r, 0, "mode");
        chk(pu, 8'hFF, "pull-up");
        $display("reset test done");
        for (i = 0; i < 12; i = i + 1)
        begin
            {l, d, m, od, op} = 21'($urandom);
            op = (op == 2'h0) ? 2'h3 : op;
            {ext, ext_en} <= 16'($urandom);
            xfer(1, `OFS_PORT_CONFIG, {29'h0, od, 2'h0});
            xfer(1, `OFS_PORT_MODE, {30'h0, m});
            xfer(1, `OFS_PORT_DATA, {24'h0, l});
            repeat (4) @(posedge mclk);
            eo = nib_mask(m) & (od ? ~l : 8'hFF);
            ev = od ? 8'h00 : l;
            chk({oe, po & oe, pu}, {eo, ev & eo, ~nib_mask(m)}, "pins");
            kn = eo | ext_en | ~nib_mask(m);
            ex = (eo & ev) | (~eo & ext_en & ext) | (~eo & ~ext_en);
            xfer(0, `OFS_PORT_DATA, 0);
            chk(r[7:0] & kn, ex & kn, "pin read");
            xfer(1, `OFS_PORT_RMW, {22'h0, op, d});
            xfer(0, `OFS_PORT_LATCH, 0);
            chk(r[7:0] & kn, (op == 2'h1 ? ex | d : op == 2'h2 ? ex & d : ex ^ d) & kn, "rmw");
        end
        $display("random test done");
        xfer(1, `OFS_PORT_MODE, 32'h3);
        swr <= 1;
        @(posedge mclk);
        swr <= 0;
        repeat (3) @(posedge mclk);
        chk(oe, 0, "stop oe");
        xfer(0, `OFS_PORT_MODE, 0);
        chk(r, 0, "stop mode");
        xfer(0, 8'h20, 0);
        chk(r, 0, "unmapped");
        $display("stop test done");
        wrap_up;
    end
endmodule
